// file: rtl/smr_slave.sv
// SMBus slave giving a master access to the register RAM and paged EEPROM.
`timescale 1ns/1ps
`include "smr_defs.svh"
module smr_slave #(
  parameter int PROG_CYC = `PROG_CYC,
  parameter int ERASE_CYC = `ERASE_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic [1:0] addr_pin,
  input wire logic pec_en,
  output logic sda_o,
  output logic sda_oe_n,
  output logic scl_o,
  output logic scl_oe_n,
  output logic pec_err
);
  import smr_pkg::*;

  smr_state_s q; // Registered state.
  smr_state_s d; // Next state.
  logic [7:0] ram [0:`RAM_DEPTH-1]; // Volatile registers.
  logic [7:0] eem [0:`EE_DEPTH-1]; // Nonvolatile array, 0xFF when blank.
  logic [7:0] crc_nx; // Remainder after byte_q.
  logic [7:0] rxb; // Byte completed by the current SCL rise.
  logic [7:0] rdata; // Byte at the pointer.
  logic rise, fall, start, stop; // Bus events, seen after synchronising.
  logic blank; // Target of the pending EEPROM write is unprogrammed.
  logic cfg_erase; // Page erase enable in the update configuration register.
  logic ld; // A transmit byte is loaded this cycle.

  smr_crc8 u_crc (
    .crc_in(q.crc),
    .data(q.byte_q),
    .crc_out(crc_nx)
  );

  // Only the second synchroniser stage and the copy behind it are looked at.
  assign rise = q.scl_s2 && !q.scl_p;
  assign fall = !q.scl_s2 && q.scl_p;
  assign start = q.scl_s2 && q.scl_p && !q.sda_s2 && q.sda_p;
  assign stop = q.scl_s2 && q.scl_p && q.sda_s2 && !q.sda_p;
  assign rxb = {q.sh[6:0], q.sda_s2};
  assign blank = eem[q.wr_addr[9:0]] == `ERASED;
  assign cfg_erase = ram[`UPD_CFG_ADDR][`UPD_ERASE_BIT];
  assign ld = fall && q.bit_n == `BIT_DONE && q.ack &&
              (q.st == S_RD || (q.st == S_ADDR && q.rd));
  // Addresses above the RAM and below the EEPROM read as blank.
  assign rdata = (q.ptr >= `EE_BASE) ? eem[q.ptr[9:0]] :
                 (q.ptr <= {8'h00, `CMD_RAM_MAX}) ? ram[q.ptr[7:0]] : `ERASED;

  // Pins are driven low only; the data level is the enable.
  assign sda_o = 1'b0;
  assign scl_o = 1'b0;
  assign sda_oe_n = q.sda_oe_n;
  assign scl_oe_n = q.scl_oe_n;
  assign pec_err = q.pec_err;

  // Next state of the bus engine, pointer, timers and check byte.
  always_comb begin
    logic [7:0] tx;
    tx = `ERASED;
    d = q;
    d.wr_req = 1'b0;
    d.crc_go = 1'b0;
    d.ers_go = 1'b0;
    d.scl_s1 = scl_i;
    d.scl_s2 = q.scl_s1;
    d.scl_p = q.scl_s2;
    d.sda_s1 = sda_i;
    d.sda_s2 = q.sda_s1;
    d.sda_p = q.sda_s2;
    d.pec_s1 = pec_en;
    d.pec_s2 = q.pec_s1;
    d.a_s1 = addr_pin;
    d.a_s2 = q.a_s1;
    if (q.crc_go) begin
      d.crc = crc_nx;
    end
    if (q.prog_cnt != '0) begin
      d.prog_cnt = q.prog_cnt - 1'b1;
    end
    // The timer starts only when the byte really programs.
    if (q.wr_req && q.wr_ee && blank) begin
      d.prog_cnt = `PROG_W'(PROG_CYC);
    end
    if (q.ers_cnt != '0) begin
      d.ers_cnt = q.ers_cnt - 1'b1;
    end
    // Stretch at the next low clock while a byte programs, so no new data lands.
    if (q.prog_cnt == '0) begin
      d.scl_oe_n = 1'b1;
    end else if (fall && q.st != S_IDLE) begin
      d.scl_oe_n = 1'b0;
    end
    if (start) begin
      // A repeated start keeps the pointer, block flag and running check.
      d.st = S_ADDR;
      d.bit_n = 4'h0;
      d.sda_oe_n = 1'b1;
    end else if (stop) begin
      d.st = S_IDLE;
      d.bit_n = 4'h0;
      d.sda_oe_n = 1'b1;
      d.crc = 8'h00;
      d.blk = 1'b0;
      d.pw = 1'b0;
      d.ers_pend = 1'b0;
      if (q.st == S_WR) begin
        d.pec_err = q.pec_s2 && q.crc != 8'h00;
      end
      // Single writes wait for the stop so that a bad check byte can drop them.
      if (q.pw && (!q.pec_s2 || q.crc == 8'h00)) begin
        d.wr_req = 1'b1;
        d.wr_ee = q.pwa >= `EE_BASE;
        d.wr_addr = q.pwa;
        d.wr_data = q.pwd;
      end
      if (q.ers_pend && cfg_erase && (!q.pec_s2 || q.crc == 8'h00)) begin
        d.ers_go = 1'b1;
        d.ers_cnt = `ERS_W'(ERASE_CYC);
      end
    end else if (q.st != S_IDLE && q.st != S_SKIP) begin
      if (rise) begin
        if (q.bit_n < `BIT_ACK) begin
          d.sh = (q.st == S_RD) ? {q.sh[6:0], 1'b1} : rxb;
          d.bit_n = q.bit_n + 4'h1;
          if (q.bit_n == `BIT_LAST && q.st == S_ADDR) begin
            // No answer at all while a page erase is still running.
            d.ack = rxb[7:1] == {`SMR_ADDR_HI, q.a_s2} && q.ers_cnt == '0;
            d.rd = rxb[0];
            d.byte_q = rxb;
            d.crc_go = d.ack;
            d.tidx = 6'h00;
            if (!rxb[0]) begin
              d.bidx = 6'h00;
              d.blk = 1'b0;
            end
          end else if (q.bit_n == `BIT_LAST && q.st == S_WR) begin
            d.ack = 1'b1;
            d.byte_q = rxb;
            d.crc_go = 1'b1;
            if (q.bidx != 6'h3F) begin
              d.bidx = q.bidx + 6'h01;
            end
            if (q.bidx == 6'h00) begin
              d.cmd = rxb;
              if (rxb <= `CMD_RAM_MAX) begin
                d.ptr = {8'h00, rxb};
              end
              d.blk = rxb == `CMD_BRD;
              d.ers_pend = rxb == `CMD_ERASE;
            end else if (q.cmd <= `CMD_RAM_MAX) begin
              if (q.bidx == 6'h01) begin
                d.pw = 1'b1;
                d.pwa = {8'h00, q.cmd};
                d.pwd = rxb;
              end
            end else if (q.cmd >= `EE_HI_MIN && q.cmd <= `EE_HI_MAX) begin
              if (q.bidx == 6'h01) begin
                d.ptr = {q.cmd, rxb};
              end else if (q.bidx == 6'h02) begin
                d.pw = 1'b1;
                d.pwa = q.ptr;
                d.pwd = rxb;
              end
            end else if (q.cmd == `CMD_BWR) begin
              if (q.bidx == 6'h01) begin
                d.bcount = rxb;
              end else if ({2'h0, q.bidx} <= q.bcount + 8'h01) begin
                // Any start address is taken; page crossing is the master's care.
                d.wr_req = 1'b1;
                d.wr_ee = q.ptr >= `EE_BASE;
                d.wr_addr = q.ptr;
                d.wr_data = rxb;
                d.ptr = q.ptr + 16'h0001;
              end
            end
          end
        end else if (q.bit_n == `BIT_DONE && q.st == S_RD && q.sda_s2) begin
          d.st = S_SKIP;
        end
      end else if (fall) begin
        if (q.bit_n == `BIT_ACK) begin
          d.bit_n = `BIT_DONE;
          d.sda_oe_n = (q.st == S_RD) ? 1'b1 : !q.ack;
        end else if (q.bit_n == `BIT_DONE) begin
          d.bit_n = 4'h0;
          d.sda_oe_n = 1'b1;
          if (!q.ack) begin
            d.st = S_SKIP;
          end else if (q.st == S_ADDR) begin
            d.st = q.rd ? S_RD : S_WR;
          end
          if (ld) begin
            if (q.blk) begin
              if (q.tidx == 6'h00) begin
                tx = `BLK_CNT;
              end else if (q.tidx <= `BLK_LEN) begin
                tx = rdata;
                d.ptr = q.ptr + 16'h0001;
              end else if (q.tidx == `TIDX_PEC) begin
                tx = q.crc;
              end
            end else if (q.tidx == 6'h00) begin
              tx = rdata;
            end
            if (q.tidx != 6'h3F) begin
              d.tidx = q.tidx + 6'h01;
            end
            d.sh = tx;
            d.sda_oe_n = tx[7];
            d.byte_q = tx;
            d.crc_go = 1'b1;
          end
        end else if (q.st == S_RD) begin
          d.sda_oe_n = q.sh[7];
        end
      end
    end
  end

  // State register; the pins idle released.
  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
      q.sda_oe_n <= 1'b1;
      q.scl_oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Memory writes and page erase; a write never overwrites a programmed byte, only the page erase does.
  always_ff @(posedge clk) begin
    if (q.wr_req) begin
      if (q.wr_ee) begin
        if (blank) begin
          eem[q.wr_addr[9:0]] <= q.wr_data;
        end
      end else if (q.wr_addr <= {8'h00, `CMD_RAM_MAX}) begin
        ram[q.wr_addr[7:0]] <= q.wr_data;
      end
    end
    if (q.ers_go) begin
      for (int i = 0; i < `PAGE_LEN; i++) begin
        eem[{q.ptr[9:5], 5'(i)}] <= `ERASED;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_erase_nack: assert property (rise && q.st == S_ADDR && q.bit_n == `BIT_LAST &&
      q.ers_cnt != '0 |=> !q.ack) else $error("address acknowledged during erase");
  a_ram_range: assert property (q.wr_req && !q.wr_ee && q.st == S_IDLE |->
      q.wr_addr <= {8'h00, `CMD_RAM_MAX}) else $error("RAM write outside range");
  a_stretch_prog: assert property (!q.scl_oe_n |-> q.prog_cnt != '0 ||
      $past(q.prog_cnt) == `PROG_W'(1)) else $error("clock held without programming");
  a_stretch_end: assert property (q.prog_cnt == `PROG_W'(1) |=> ##1 q.scl_oe_n)
      else $error("clock not released after programming");
  a_block_count: assert property (ld && q.blk && q.tidx == 6'h00 |=>
      q.sh == `BLK_CNT && !q.sda_oe_n) else $error("block count byte wrong");
  a_pec_byte: assert property (ld && q.blk && q.tidx == `TIDX_PEC |=>
      q.sh == $past(q.crc)) else $error("check byte differs from remainder");
  a_ptr_step: assert property ($changed(q.ptr) && (q.blk || q.cmd == `CMD_BWR) |->
      q.ptr == $past(q.ptr) + 16'h0001) else $error("pointer did not step by one");
  a_erase_cfg: assert property (q.ers_go |-> $past(cfg_erase) &&
      q.ers_cnt == `ERS_W'(ERASE_CYC)) else $error("erase without enable");
  a_prog_blank: assert property ($rose(q.prog_cnt == `PROG_W'(PROG_CYC)) |->
      $past(q.wr_req && q.wr_ee && blank)) else $error("programming a used byte");
  a_sda_ack: assert property (fall && q.st == S_WR && q.bit_n == `BIT_ACK |=>
      !q.sda_oe_n ##0 q.bit_n == `BIT_DONE) else $error("write byte not acknowledged");
endmodule

// file: rtl/smr_defs.svh
// Constants of the SMBus RAM and EEPROM access slave.
// How it works
// - Command 0x00-0xDF then data writes RAM
// - Command 0xF8-0xFB plus low byte sets pointer
// - Erase uses low byte top three bits
// - High, low, data bytes program one EEPROM byte
// - Command 0xFC, count, data bytes, all acknowledged
// - Block transfers start at earlier set pointer
// - Block may cross pages; master erases both
// - Hold SCL low while byte programs
// - Receive byte returns byte at pointer
// - Command 0xFD then repeated start reads block
// - Block read sends 0x20 then 32 bytes
// - Optional check byte on writes and block reads
// - Check byte follows last block read byte
// - Check byte is CRC-8, polynomial 0x07
// - Each write byte/word byte is acknowledged
// - Send byte 0xFE erases the pointed page
// - Erase only when config bit 2 set
// - Refuse access while erase runs
// - Program only blank bytes
`ifndef SMR_DEFS_SVH
`define SMR_DEFS_SVH
`define SMR_ADDR_HI 5'h11
`define CMD_RAM_MAX 8'hDF
`define EE_HI_MIN 8'hF8
`define EE_HI_MAX 8'hFB
`define EE_BASE 16'hF800
`define CMD_BWR 8'hFC
`define CMD_BRD 8'hFD
`define CMD_ERASE 8'hFE
`define BLK_CNT 8'h20
`define BLK_LEN 6'h20
`define TIDX_PEC 6'h21
`define ERASED 8'hFF
`define RAM_DEPTH 224
`define EE_DEPTH 1024
`define PAGE_LEN 32
`define UPD_CFG_ADDR 8'h90
`define UPD_ERASE_BIT 2
`define CRC_POLY 8'h07
`define BIT_LAST 4'h7
`define BIT_ACK 4'h8
`define BIT_DONE 4'h9
`define CLK_MHZ 20
`define PROG_US 250
`define ERASE_MS 20
`define PROG_CYC (`PROG_US * `CLK_MHZ)
`define ERASE_CYC (`ERASE_MS * 1000 * `CLK_MHZ)
`define PROG_W 13
`define ERS_W 19
`endif

// file: rtl/smr_pkg.sv
// Types shared by the SMBus RAM and EEPROM access slave.
`include "smr_defs.svh"
package smr_pkg;
  // Transfer phase of the slave.
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_WR, S_RD, S_SKIP} smr_state_e;
  // Whole state of the slave, registered at once.
  typedef struct packed {
    smr_state_e st;
    logic scl_s1, scl_s2, scl_p, sda_s1, sda_s2, sda_p, pec_s1, pec_s2;
    logic [1:0] a_s1, a_s2;
    logic [3:0] bit_n;
    logic [7:0] sh;
    logic ack, rd, blk, pw, ers_pend, crc_go, wr_req, wr_ee, ers_go;
    logic [5:0] bidx, tidx;
    logic [7:0] cmd, bcount, pwd, byte_q, crc, wr_data;
    logic [15:0] ptr, pwa, wr_addr;
    logic [`PROG_W-1:0] prog_cnt;
    logic [`ERS_W-1:0] ers_cnt;
    logic sda_oe_n, scl_oe_n, pec_err;
  } smr_state_s;
endpackage

// file: rtl/smr_crc8.sv
// One byte step of the CRC-8 packet check.
`timescale 1ns/1ps
`include "smr_defs.svh"
module smr_crc8 (
  input wire logic [7:0] crc_in,
  input wire logic [7:0] data,
  output logic [7:0] crc_out
);
  // Bitwise shift of the byte into the remainder, MSB first.
  always_comb begin
    logic [7:0] c;
    c = crc_in ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ({c[6:0], 1'b0} ^ `CRC_POLY) : {c[6:0], 1'b0};
    end
    crc_out = c;
  end
endmodule

// file: verification/smr_host.sv
// Behavioural SMBus host that drives the bus in front of the slave.
`timescale 1ns/1ps
module smr_host (
  input wire logic clk,
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  input wire logic scl_o,
  input wire logic sda_o,
  output logic scl_w,
  output logic sda_w
);
  logic scl_m = 1'b1; // Host clock drive, high when released.
  logic sda_m = 1'b1; // Host data drive, high when released.
  // Both lines have pull-ups, so a released line reads high.
  // An enabled slave driver puts its output value on the line.
  assign scl_w = scl_m & (scl_oe_n | scl_o);
  assign sda_w = sda_m & (sda_oe_n | sda_o);
  // Waits a number of falling clock edges, where the host changes its lines.
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Releases the clock, waiting a bounded time while the slave stretches it.
  task automatic rise();
    scl_m = 1'b1;
    for (int i = 0; i < 3000 && scl_w !== 1'b1; i++) hold(1);
    hold(4);
  endtask
  // Start, also used as repeated start from a low clock.
  task automatic start();
    sda_m = 1'b1;
    hold(6);
    rise();
    sda_m = 1'b0;
    hold(6);
    scl_m = 1'b0;
    hold(2);
  endtask
  // Stop ends every transfer of the host.
  task automatic stop();
    sda_m = 1'b0;
    hold(6);
    rise();
    sda_m = 1'b1;
    hold(12);
  endtask
  // One bit: data set while the clock is low, sampled while it is high.
  task automatic bit_x(input logic b, output logic r);
    sda_m = b;
    hold(6);
    rise();
    r = sda_w;
    hold(4);
    scl_m = 1'b0;
    hold(2);
  endtask
  // Sends a byte MSB first and returns the slave's acknowledge.
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask
  // Reads a byte; the host acks to go on and nacks the last one.
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(~ack, r);
  endtask
endmodule

// file: verification/smr_slave_tb.sv
// Self-checking testbench of the SMBus RAM and EEPROM slave.
`timescale 1ns/1ps
module smr_slave_tb;
  logic clk, reset, pec_en, scl_w, sda_w, sda_oe_n, scl_oe_n, pec_err, sda_o, scl_o;
  logic [1:0] addr_pin;
  logic [7:0] aw; // Write address byte of the slave.
  logic [7:0] mem [0:255]; // Expected RAM contents.
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int n_str = 0; // Clock edges seen with the clock stretched.
  // Short programming and erase counts keep the run brief.
  // The erase count still outlasts the address byte of the next transfer.
  smr_slave #(.PROG_CYC(400), .ERASE_CYC(300)) i_dut (.clk(clk), .reset(reset),
    .scl_i(scl_w), .sda_i(sda_w), .addr_pin(addr_pin), .pec_en(pec_en), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .pec_err(pec_err));
  smr_host i_host (.clk(clk), .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .scl_o(scl_o),
    .sda_o(sda_o), .scl_w(scl_w), .sda_w(sda_w));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Cycle ceiling well above the expected run, so a hang cannot stall it.
  always @(posedge clk) begin
    cyc++;
    if (scl_oe_n === 1'b0) n_str++;
    if (cyc == 90000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("Checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One CRC-8 step, polynomial 0x07.
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int i = 0; i < 8; i++) x = x[7] ? {x[6:0], 1'b0} ^ 8'h07 : {x[6:0], 1'b0};
    return x;
  endfunction
  // Write transfer of the given bytes; n counts acknowledged bytes.
  task automatic wr(input logic [7:0] b [$], output int n);
    logic a;
    n = 0;
    i_host.start();
    foreach (b[i]) begin
      i_host.wbyte(b[i], a);
      n += int'(a);
    end
    i_host.stop();
  endtask
  // Sets the pointer with the given bytes, then a receive byte.
  task automatic rd_at(input logic [7:0] b [$], output logic [7:0] v);
    logic a;
    int n;
    wr(b, n);
    i_host.start();
    i_host.wbyte(aw | 8'h01, a);
    i_host.rbyte(1'b0, v);
    i_host.stop();
  endtask
  // Block read from RAM address p with its check byte.
  task automatic brd(input logic [7:0] p);
    logic [7:0] v;
    logic [7:0] c;
    logic a;
    int n;
    wr({aw, p}, n);
    i_host.start();
    i_host.wbyte(aw, a);
    i_host.wbyte(8'hFD, a);
    i_host.start();
    i_host.wbyte(aw | 8'h01, a);
    chk("brd_ack", {7'h0, a}, 8'h01);
    c = crc8(crc8(crc8(8'h00, aw), 8'hFD), aw | 8'h01);
    i_host.rbyte(1'b1, v);
    chk("brd_count", v, 8'h20);
    c = crc8(c, 8'h20);
    for (int i = 0; i < 32; i++) begin
      i_host.rbyte(1'b1, v);
      chk("brd_data", v, mem[8'(p + i)]);
      c = crc8(c, mem[8'(p + i)]);
    end
    i_host.rbyte(1'b0, v);
    chk("brd_pec", v, c);
    i_host.stop();
  endtask
  initial begin
    logic [7:0] p, d, v, pc, hi, lo;
    logic [7:0] q [$];
    int n, s0;
    reset = 1'b1;
    pec_en = 1'b0;
    addr_pin = 2'h0;
    void'($urandom(32'h1552));
    addr_pin = 2'($urandom);
    aw = {5'h11, addr_pin, 1'b0};
    repeat (20) @(negedge clk);
    reset = 1'b0;
    i_host.hold(10);
    // Single RAM writes, the top address first, read back by receive byte.
    for (int k = 0; k < 5; k++) begin
      p = (k == 0) ? 8'hDF : 8'($urandom_range(8'h8F));
      d = 8'($urandom);
      wr({aw, p, d}, n);
      chk("ram_wr_ack", 8'(n), 8'h03);
      mem[p] = d;
      rd_at({aw, p}, v);
      chk("ram_rd", v, d);
    end
    // A changed strap moves the slave off the old address, which is then ignored.
    addr_pin = addr_pin + 2'h1;
    wr({aw, 8'h00}, n);
    chk("addr_miss", 8'(n), 8'h00);
    aw = {5'h11, addr_pin, 1'b0};
    // Block writes of 32 bytes and then a shorter random count.
    for (int k = 0; k < 2; k++) begin
      q = {aw, 8'hFC, 8'h00};
      q[2] = (k == 0) ? 8'h20 : 8'($urandom_range(31, 1));
      for (int i = 0; i < q[2]; i++) q.push_back(8'($urandom));
      for (int i = 0; i < q[2]; i++) mem[8'hA0 + i] = q[3 + i];
      wr({aw, 8'hA0}, n);
      wr(q, n);
      chk("bwr_ack", 8'(n), 8'(q.size()));
      brd(8'hA0);
    end
    // Checked writes: a correct check byte commits, a wrong one is refused.
    p = 8'($urandom_range(8'h8F));
    d = 8'($urandom);
    pc = crc8(crc8(crc8(8'h00, aw), p), d);
    @(negedge clk) pec_en = 1'b1;
    wr({aw, p, d, pc}, n);
    chk("pec_ok", {7'h0, pec_err}, 8'h00);
    wr({aw, p, ~d, pc}, n);
    chk("pec_bad", {7'h0, pec_err}, 8'h01);
    pec_en = 1'b0;
    rd_at({aw, p}, v);
    chk("pec_data", v, d);
    // Page erase, refusal while erasing, programming with stretch.
    hi = 8'hF8 + 8'($urandom_range(3));
    lo = {3'($urandom_range(6)), 5'($urandom_range(29))};
    d = 8'($urandom_range(8'hFE));
    wr({aw, 8'h90, 8'h04}, n);
    wr({aw, hi, lo}, n);
    wr({aw, 8'hFE}, n);
    wr({aw, hi, lo}, n);
    chk("erase_nack", 8'(n), 8'h00);
    i_host.hold(100);
    rd_at({aw, hi, lo ^ 8'h1F}, v);
    chk("erased", v, 8'hFF);
    // Short block write crossing into the next page; both pages are erased first.
    p = {lo[7:5], 5'h1E};
    pc = p + 8'h03;
    wr({aw, hi, pc}, n);
    wr({aw, 8'hFE}, n);
    i_host.hold(400);
    wr({aw, hi, p}, n);
    q = {aw, 8'hFC, 8'h04};
    for (int i = 0; i < 4; i++) q.push_back(8'($urandom));
    wr(q, n);
    chk("bwr_ee_ack", 8'(n), 8'h07);
    rd_at({aw, hi, p}, v);
    chk("bwr_ee_first", v, q[3]);
    rd_at({aw, hi, pc}, v);
    chk("bwr_ee_cross", v, q[6]);
    s0 = n_str;
    wr({aw, hi, lo, d}, n);
    chk("ee_wr_ack", 8'(n), 8'h04);
    rd_at({aw, hi, lo}, v);
    chk("ee_rd", v, d);
    chk("stretch", 8'(n_str > s0), 8'h01);
    wr({aw, hi, lo, ~d}, n);
    i_host.hold(500);
    rd_at({aw, hi, lo}, v);
    chk("no_rewrite", v, d);
    wr({aw, 8'h90, 8'h00}, n);
    wr({aw, hi, lo}, n);
    wr({aw, 8'hFE}, n);
    i_host.hold(100);
    rd_at({aw, hi, lo}, v);
    chk("erase_off", v, d);
    end_sim();
  end
endmodule
